// file: logic/tks_scan_ctrl.sv
// Notes on behaviour
// - Stop clears counters, keeps slot timer
// - Start edge launches counters and oscillator
// - C/F overflow sets flag, software clears
// - Reference overflow sets flag, software clears
// - Share bit selects module 0 slots
// - Two-bit field selects reference counter clock
// - Slot period is 32 times (256-preset)
`timescale 1ns/1ps
`default_nettype none
module tks_scan_ctrl
   import tks_pkg::*;
#(
   parameter int NUM_MODULES = 3
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   output logic [31:0] wb_dat_r,
   output logic wb_ack,
   input wire logic [NUM_MODULES-1:0] cf_tick,
   output logic [NUM_MODULES-1:0] key_osc_en,
   output logic irq
);
   // ==========================================================
   // Elaboration check
   // Eight modules keep every counter address inside the byte map
   if (NUM_MODULES < 1 || NUM_MODULES > 8) begin : g_bad_num
      $error("NUM_MODULES must lie between 1 and 8");
   end

   // Control and status state
   logic start_r;
   logic start_prev_r;
   logic share_r;
   logic [1:0] clksel_r;
   logic cf_ov_r;
   logic ref_ov_r;
   logic slot_ov_r;
   logic [7:0] preset_r;
   logic [TKS_IRQ_W-1:0] irq_stat_r;
   logic [TKS_IRQ_W-1:0] irq_mask_r;
   logic [31:0] wb_dat_r_r;
   logic wb_ack_r;
   logic irq_r;
   logic [NUM_MODULES-1:0] key_osc_en_r;

   // Module side wires
   logic ref_tick;
   logic launch;
   logic [NUM_MODULES-1:0] cf_ovf;
   logic [NUM_MODULES-1:0] ref_ovf;
   logic [NUM_MODULES-1:0] slot_ovf;
   logic [15:0] cf_cnt [NUM_MODULES];
   logic [15:0] ref_cnt [NUM_MODULES];
   logic any_cf_ovf;
   logic any_ref_ovf;
   logic slot_event;

   // Bus decode wires
   logic req;
   logic wr_lo;
   logic wr_ctrl;
   logic [7:0] ctrl_rd;
   logic [31:0] rd_nxt;
   logic [TKS_IRQ_W-1:0] events;
   logic hit_ctrl;
   logic hit_preset;
   logic hit_stat;
   logic hit_mask;
   logic clr_cf;
   logic clr_ref;
   logic clr_slot;
   logic [TKS_IRQ_W-1:0] stat_clr;
   logic irq_nxt;

   // ==========================================================
   // Bus decode
   // Request is taken once; ack drops the cycle after it was given
   assign req = wb_cyc & wb_stb & ~wb_ack_r;
   // Only byte lane 0 carries writable register bits, so it gates every write
   assign wr_lo = req & wb_we & wb_sel[0];

   // Full eight bit compare, so aliases of a register read as zero
   assign hit_ctrl = (wb_adr == TKS_OFS_CTRL);
   assign hit_preset = (wb_adr == TKS_OFS_PRESET);
   assign hit_stat = (wb_adr == TKS_OFS_IRQ_STAT);
   assign hit_mask = (wb_adr == TKS_OFS_IRQ_MASK);
   assign wr_ctrl = wr_lo & hit_ctrl;

   // Control flags clear on a written zero; a one leaves them alone
   assign clr_cf = wr_ctrl & ~wb_dat_w[TKS_BIT_CF_OV];
   assign clr_ref = wr_ctrl & ~wb_dat_w[TKS_BIT_REF_OV];
   assign clr_slot = wr_ctrl & ~wb_dat_w[TKS_BIT_SLOT_OV];

   // Status bits clear on a written one
   assign stat_clr = (wr_lo & hit_stat) ? wb_dat_w[TKS_IRQ_W-1:0] : {TKS_IRQ_W{1'b0}};

   // Writing one over a running scan is no edge, so nothing restarts
   // start edge
   assign launch = start_r & ~start_prev_r;

   // ==========================================================
   // Reference counter clock
   // The divider free runs; the first tick after a select change may come early
   tks_prescale u_prescale (
      .clk(clk),
      .srst(srst),
      .ce(ce),
      .div_sel(clksel_r),
      .tick(ref_tick)
   );

   // ==========================================================
   // Touch module counter units
   // Every module sees the same start, preset and reference tick
   for (genvar n = 0; n < NUM_MODULES; n++) begin : g_mod
      logic done_src;
      assign done_src = share_r ? slot_ovf[0] : slot_ovf[n];
      tks_channel u_chan (
         .clk(clk),
         .srst(srst),
         .ce(ce),
         .run(start_r),
         .launch(launch),
         .cf_tick(cf_tick[n]),
         .ref_tick(ref_tick),
         .preset(preset_r),
         .slot_done(done_src),
         .cf_cnt(cf_cnt[n]),
         .ref_cnt(ref_cnt[n]),
         .cf_ovf(cf_ovf[n]),
         .ref_ovf(ref_ovf[n]),
         .slot_ovf(slot_ovf[n])
      );
   end

   // Overflow events gathered over all modules
   assign any_cf_ovf = |cf_ovf;
   assign any_ref_ovf = |ref_ovf;
   // With sharing, only module 0 ends the slot for everyone
   assign slot_event = share_r ? slot_ovf[0] : |slot_ovf;
   // Bit order matches the status and mask layout
   assign events = {slot_event, any_ref_ovf, any_cf_ovf};

   // ==========================================================
   // Control bits
   // A clock select change applies at once; the divider keeps its phase
   // reset to zero
   always_ff @(posedge clk) begin
      if (srst) begin
         start_r <= TKS_CTRL_RESET[TKS_BIT_START];
         share_r <= TKS_CTRL_RESET[TKS_BIT_SHARE];
         clksel_r <= TKS_CTRL_RESET[TKS_BIT_CLKSEL_HI:TKS_BIT_CLKSEL_LO];
         start_prev_r <= 1'b0;
      end else if (ce) begin
         start_prev_r <= start_r;
         if (wr_ctrl) begin
            start_r <= wb_dat_w[TKS_BIT_START];
            share_r <= wb_dat_w[TKS_BIT_SHARE];
            clksel_r <= wb_dat_w[TKS_BIT_CLKSEL_HI:TKS_BIT_CLKSEL_LO];
         end
      end
   end

   // Overflow flags: writing zero clears, a new event in the same cycle wins
   // C/F flag
   always_ff @(posedge clk) begin
      if (srst) begin
         cf_ov_r <= TKS_CTRL_RESET[TKS_BIT_CF_OV];
      end else if (ce) begin
         if (any_cf_ovf) begin
            cf_ov_r <= 1'b1;
         end else if (clr_cf) begin
            cf_ov_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         ref_ov_r <= TKS_CTRL_RESET[TKS_BIT_REF_OV];
      end else if (ce) begin
         if (any_ref_ovf) begin
            ref_ov_r <= 1'b1;
         end else if (clr_ref) begin
            ref_ov_r <= 1'b0;
         end
      end
   end

   // Slot overflow flag follows the same clearing scheme
   always_ff @(posedge clk) begin
      if (srst) begin
         slot_ov_r <= TKS_CTRL_RESET[TKS_BIT_SLOT_OV];
      end else if (ce) begin
         if (slot_event) begin
            slot_ov_r <= 1'b1;
         end else if (clr_slot) begin
            slot_ov_r <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Slot period preset
   // A new preset is picked up at the next start or timer wrap
   always_ff @(posedge clk) begin
      if (srst) begin
         preset_r <= TKS_PRESET_RESET;
      end else if (ce && wr_lo && hit_preset) begin
         preset_r <= wb_dat_w[7:0];
      end
   end

   // ==========================================================
   // Interrupt status (write one to clear, set wins) and mask
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_stat_r <= TKS_IRQ_RESET;
         irq_mask_r <= TKS_IRQ_RESET;
      end else if (ce) begin
         // A new event outranks a clear that lands in the same cycle
         irq_stat_r <= (irq_stat_r & ~stat_clr) | events;
         // Mask writes never touch status, so masked events stay visible
         if (wr_lo && hit_mask) begin
            irq_mask_r <= wb_dat_w[TKS_IRQ_W-1:0];
         end
      end
   end

   // Level request; registered so the pin never glitches on a decode
   assign irq_nxt = |(irq_stat_r & irq_mask_r);

   // Registered outputs; the oscillator enable lags start by one cycle
   // oscillator enable
   always_ff @(posedge clk) begin
      if (srst) begin
         irq_r <= 1'b0;
         key_osc_en_r <= '0;
      end else if (ce) begin
         irq_r <= irq_nxt;
         key_osc_en_r <= {NUM_MODULES{start_r}};
      end
   end

   // ==========================================================
   // Read data
   // top bit zero
   assign ctrl_rd = {1'b0, slot_ov_r, start_r, cf_ov_r, ref_ov_r, share_r, clksel_r};

   // Counter reads are live; wait for the slot flag first, since stopping the scan clears them
   // Unmapped addresses read as zero
   always_comb begin
      rd_nxt = 32'h0000_0000;
      if (hit_ctrl) begin
         rd_nxt = {24'h00_0000, ctrl_rd};
      end else if (hit_preset) begin
         rd_nxt = {24'h00_0000, preset_r};
      end else if (hit_stat) begin
         rd_nxt = {29'h0000_0000, irq_stat_r};
      end else if (hit_mask) begin
         rd_nxt = {29'h0000_0000, irq_mask_r};
      end
      for (int i = 0; i < NUM_MODULES; i++) begin
         if (wb_adr == TKS_OFS_CNT_BASE + 8'(i) * TKS_CNT_STRIDE) begin
            rd_nxt = {16'h0000, cf_cnt[i]};
         end
         if (wb_adr == TKS_OFS_CNT_BASE + 8'(i) * TKS_CNT_STRIDE + TKS_CNT_REF_OFS) begin
            rd_nxt = {16'h0000, ref_cnt[i]};
         end
      end
   end

   // Single wait state answer; every address is acknowledged
   // Read data is captured with ack and held until the next read
   always_ff @(posedge clk) begin
      if (srst) begin
         wb_ack_r <= 1'b0;
         wb_dat_r_r <= 32'h0000_0000;
      end else if (ce) begin
         wb_ack_r <= req;
         if (req && !wb_we) begin
            wb_dat_r_r <= rd_nxt;
         end
      end
   end

   // Outputs straight from their registers
   assign wb_ack = wb_ack_r;
   assign wb_dat_r = wb_dat_r_r;
   assign irq = irq_r;
   assign key_osc_en = key_osc_en_r;
endmodule
`default_nettype wire

// file: logic/tks_pkg.sv
`default_nettype none
package tks_pkg;
   // ==========================================================
   // Register byte offsets on the Wishbone slave
   localparam logic [7:0] TKS_OFS_CTRL = 8'h00;
   localparam logic [7:0] TKS_OFS_PRESET = 8'h04;
   localparam logic [7:0] TKS_OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] TKS_OFS_IRQ_MASK = 8'h0c;
   localparam logic [7:0] TKS_OFS_CNT_BASE = 8'h20;
   localparam logic [7:0] TKS_CNT_STRIDE = 8'h08;
   localparam logic [7:0] TKS_CNT_REF_OFS = 8'h04;

   // ==========================================================
   // Field positions of touch_scan_control
   localparam int TKS_BIT_SLOT_OV = 6;
   localparam int TKS_BIT_START = 5;
   localparam int TKS_BIT_CF_OV = 4;
   localparam int TKS_BIT_REF_OV = 3;
   localparam int TKS_BIT_SHARE = 2;
   localparam int TKS_BIT_CLKSEL_HI = 1;
   localparam int TKS_BIT_CLKSEL_LO = 0;

   // Interrupt status and mask layout
   localparam int TKS_IRQ_CF = 0;
   localparam int TKS_IRQ_REF = 1;
   localparam int TKS_IRQ_SLOT = 2;
   localparam int TKS_IRQ_W = 3;

   // ==========================================================
   // Reset values and counter limits
   localparam logic [7:0] TKS_CTRL_RESET = 8'h00;
   localparam logic [7:0] TKS_PRESET_RESET = 8'h00;
   localparam logic [TKS_IRQ_W-1:0] TKS_IRQ_RESET = 3'h0;
   localparam logic [15:0] TKS_CNT16_MAX = 16'hffff;
   localparam logic [7:0] TKS_TMR_MAX = 8'hff;
   localparam logic [4:0] TKS_SLOT_MAX = 5'h1f;

   // Reference counter clock divider codes
   localparam logic [1:0] TKS_DIV1 = 2'h0;
   localparam logic [1:0] TKS_DIV2 = 2'h1;
   localparam logic [1:0] TKS_DIV4 = 2'h2;
   localparam logic [1:0] TKS_DIV8 = 2'h3;
endpackage
`default_nettype wire

// file: logic/tks_prescale.sv
`timescale 1ns/1ps
`default_nettype none
module tks_prescale
   import tks_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic [1:0] div_sel,
   output logic tick
);
   logic [2:0] div_cnt_r;
   logic [2:0] mask;

   // ==========================================================
   // Free running divider
   always_ff @(posedge clk) begin
      if (srst) begin
         div_cnt_r <= 3'h0;
      end else if (ce) begin
         div_cnt_r <= div_cnt_r + 3'h1;
      end
   end

   // Code 00 is the undivided clock, others divide by 2, 4, 8
   // clock select decode
   always_comb begin
      unique case (div_sel)
         TKS_DIV1: mask = 3'h0;
         TKS_DIV2: mask = 3'h1;
         TKS_DIV4: mask = 3'h3;
         TKS_DIV8: mask = 3'h7;
      endcase
   end

   // Tick when the masked bits are all ones
   assign tick = ((div_cnt_r & mask) == mask);
endmodule
`default_nettype wire

// file: logic/tks_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tks_channel
   import tks_pkg::*;
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic run,
   input wire logic launch,
   input wire logic cf_tick,
   input wire logic ref_tick,
   input wire logic [7:0] preset,
   input wire logic slot_done,
   output logic [15:0] cf_cnt,
   output logic [15:0] ref_cnt,
   output logic cf_ovf,
   output logic ref_ovf,
   output logic slot_ovf
);
   logic [15:0] cf_cnt_r;
   logic [15:0] ref_cnt_r;
   logic [7:0] tmr_r;
   logic [4:0] slot_r;
   logic halt_r;
   logic active;
   logic tmr_wrap;

   // Counting stops at the end of the time slot until the next start
   assign active = run & ~halt_r;
   // The launch cycle only loads the timer; a stale 0xff left from an
   // earlier run must not count as a slot there
   assign tmr_wrap = active & ~launch & (tmr_r == TKS_TMR_MAX);
   assign cf_ovf = active & cf_tick & (cf_cnt_r == TKS_CNT16_MAX);
   assign ref_ovf = active & ref_tick & (ref_cnt_r == TKS_CNT16_MAX);
   assign slot_ovf = tmr_wrap & (slot_r == TKS_SLOT_MAX);
   assign cf_cnt = cf_cnt_r;
   assign ref_cnt = ref_cnt_r;

   // ==========================================================
   // Slot end latch
   // slot source end
   always_ff @(posedge clk) begin
      if (srst) begin
         halt_r <= 1'b0;
      end else if (ce) begin
         if (!run) begin
            halt_r <= 1'b0;
         end else if (slot_done) begin
            halt_r <= 1'b1;
         end
      end
   end

   // Measurement counters, cleared whenever the scan is stopped
   // clear on stop
   always_ff @(posedge clk) begin
      if (srst) begin
         cf_cnt_r <= 16'h0000;
         ref_cnt_r <= 16'h0000;
         slot_r <= 5'h00;
      end else if (ce) begin
         if (!run) begin
            cf_cnt_r <= 16'h0000;
            ref_cnt_r <= 16'h0000;
            slot_r <= 5'h00;
         end else if (active) begin
            if (cf_tick) begin
               cf_cnt_r <= cf_cnt_r + 16'h0001;
            end
            if (ref_tick) begin
               ref_cnt_r <= ref_cnt_r + 16'h0001;
            end
            if (tmr_wrap) begin
               slot_r <= slot_r + 5'h01;
            end
         end
      end
   end

   // Programmable slot timer keeps its value while stopped
   // timer untouched
   always_ff @(posedge clk) begin
      if (srst) begin
         tmr_r <= TKS_PRESET_RESET;
      end else if (ce) begin
         if (launch || tmr_wrap) begin
            tmr_r <= preset;
         end else if (active) begin
            tmr_r <= tmr_r + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

// file: test/tks_scan_ctrl_sva.sv
`timescale 1ns/1ps
`default_nettype none
module tks_scan_ctrl_sva
   import tks_pkg::*;
#(
   parameter int NUM_MODULES = 3
)
(
   input wire logic clk,
   input wire logic srst,
   input wire logic ce,
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [7:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_w,
   input wire logic [31:0] wb_dat_r,
   input wire logic wb_ack,
   input wire logic [NUM_MODULES-1:0] cf_tick,
   input wire logic [NUM_MODULES-1:0] key_osc_en,
   input wire logic irq
);
   // ==========================================================
   // Decoded bus events
   logic taken;
   logic ctrl_wr;
   logic rd_ack;
   assign taken = ce && wb_cyc && wb_stb && !wb_ack;
   // Lane 0 must be enabled, otherwise the control byte is untouched
   assign ctrl_wr = taken && wb_we && wb_sel[0] && (wb_adr == TKS_OFS_CTRL);
   assign rd_ack = wb_ack && !wb_we;

   // ==========================================================
   // Properties, all in the single clock domain
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_ack_answer: assert property (taken |=> wb_ack)
      else $error("ack missing one cycle after request");
   a_ack_single: assert property (wb_ack |=> !wb_ack)
      else $error("ack longer than one cycle");
   a_reset_quiet: assert property (
      $fell(srst) |-> !wb_ack && !irq && key_osc_en == '0)
      else $error("outputs not quiet after reset");
   a_osc_start: assert property (
      ctrl_wr && wb_dat_w[TKS_BIT_START] |-> ##2 key_osc_en == '1)
      else $error("oscillator enable missing after start");
   a_osc_stop: assert property (
      ctrl_wr && !wb_dat_w[TKS_BIT_START] |-> ##2 key_osc_en == '0)
      else $error("oscillator enable stays after stop");
   a_osc_cause: assert property (
      $changed(key_osc_en) |-> $past(ctrl_wr, 2))
      else $error("oscillator enable moved without a control write");
   a_ctrl_top_zero: assert property (
      rd_ack && wb_adr == TKS_OFS_CTRL |-> wb_dat_r[31:7] == '0)
      else $error("control upper bits not zero");
   a_count_cleared: assert property (
      rd_ack && wb_adr >= TKS_OFS_CNT_BASE && key_osc_en == '0 && $past(key_osc_en) == '0
      && $past(key_osc_en, 2) == '0 |-> wb_dat_r == '0)
      else $error("counter not cleared while stopped");
   a_unmapped_zero: assert property (rd_ack && wb_adr == 8'h10 |-> wb_dat_r == '0)
      else $error("unmapped read not zero");
   // Clock enable low freezes every register, the outputs included
   a_freeze_hold: assert property (!ce |=> $stable(wb_ack) && $stable(wb_dat_r)
      && $stable(key_osc_en) && $stable(irq))
      else $error("outputs moved while clock enable low");
endmodule

bind tks_scan_ctrl tks_scan_ctrl_sva #(.NUM_MODULES(NUM_MODULES)) u_sva (
   .clk(clk), .srst(srst), .ce(ce), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
   .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
   .wb_ack(wb_ack), .cf_tick(cf_tick), .key_osc_en(key_osc_en), .irq(irq));
`default_nettype wire

// file: test/test_tks_scan_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
module test_tks_scan_ctrl
   import tks_pkg::*;
;
   // ==========================================================
   // Stimulus signals
   localparam int N = 3;
   localparam int P = 32 * (256 - 8'hf0);
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic ce = 1'b1;
   logic cyc = 1'b0;
   logic stb = 1'b0;
   logic we = 1'b0;
   logic [7:0] adr = 8'h00;
   logic [3:0] sel = 4'hf;
   logic [31:0] dat_w = 32'h0;
   logic [31:0] dat_r;
   logic ack;
   logic [N-1:0] cf_tick = '0;
   logic [N-1:0] osc;
   logic irq;
   logic [31:0] q;
   int failures = 0;
   int n_checks = 0;
   int cyc_n = 0;
   int t0;

   always #5 clk = ~clk;

   // Module 0 ticks every cycle, module 1 every other one, module 2 never
   always @(posedge clk) begin
      cyc_n <= cyc_n + 1;
      cf_tick <= {1'b0, ~cf_tick[1], 1'b1};
   end

   tks_scan_ctrl #(.NUM_MODULES(N)) dut (
      .clk(clk), .srst(srst), .ce(ce), .wb_cyc(cyc), .wb_stb(stb), .wb_we(we),
      .wb_adr(adr), .wb_sel(sel), .wb_dat_w(dat_w), .wb_dat_r(dat_r), .wb_ack(ack),
      .cf_tick(cf_tick), .key_osc_en(osc), .irq(irq));

   // ==========================================================
   // Report and compare
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g,
                        input int tol = 0);
      n_checks++;
      // Counts near a free running divider may be off by a tick
      if ((tol == 0) ? (g !== e) : ((^g === 1'bx) || g + tol < e || g > e + tol)) begin
         failures++;
         $display("BAD %s expected %0h seen %0h", nm, e, g);
      end
   endtask

   task automatic give_up(input string nm);
      failures++;
      $display("BAD %s expected done seen timeout", nm);
      tally_and_finish();
   endtask

   // ==========================================================
   // Classic single cycle, held until ack is sampled
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat_w <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 50);
      q = dat_r;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (ack !== 1'b1) give_up("ack");
   endtask

   task automatic rd(input string nm, input logic [7:0] a, input logic [31:0] e,
                     input int tol = 0);
      bus(1'b0, a, 32'h0);
      check(nm, e, q, tol);
   endtask

   // Poll until the slot overflow flag shows in control
   task automatic wait_slot();
      int n;
      n = 0;
      do begin
         bus(1'b0, TKS_OFS_CTRL, 32'h0);
         n++;
      end while (q[TKS_BIT_SLOT_OV] !== 1'b1 && n < 400);
      if (q[TKS_BIT_SLOT_OV] !== 1'b1) give_up("slot");
   endtask

   // ==========================================================
   // Main sequence
   initial begin
      repeat (4) @(posedge clk);
      srst <= 1'b0;
      rd("ctrl", TKS_OFS_CTRL, 32'h0);
      rd("preset", TKS_OFS_PRESET, 32'h0);
      rd("irq_stat", TKS_OFS_IRQ_STAT, 32'h0);
      rd("irq_mask", TKS_OFS_IRQ_MASK, 32'h0);
      bus(1'b1, 8'h10, 32'hff);
      rd("unmapped", 8'h10, 32'h0);
      check("irq", 32'h0, {31'h0, irq});
      $display("test reset done");
      // Flags cannot be set by software, bit 7 never sticks
      bus(1'b1, TKS_OFS_CTRL, 32'hdf);
      rd("ctrl", TKS_OFS_CTRL, 32'h07);
      bus(1'b1, TKS_OFS_CTRL, 32'h04);
      rd("ctrl", TKS_OFS_CTRL, 32'h04);
      $display("test fields done");
      bus(1'b1, TKS_OFS_PRESET, 32'hf0);
      rd("preset", TKS_OFS_PRESET, 32'hf0);
      for (int c = 0; c < 4; c++) begin
         bus(1'b1, TKS_OFS_CTRL, 32'h20 | c);
         t0 = cyc_n;
         wait_slot();
         check("slot_time", P + 2, cyc_n - t0, 4);
         check("osc", 32'h7, 32'(osc));
         rd("cf0", TKS_OFS_CNT_BASE, P, 2);
         rd("cf1", TKS_OFS_CNT_BASE + TKS_CNT_STRIDE, P / 2, 2);
         rd("cf2", TKS_OFS_CNT_BASE + 8'h10, 32'h0);
         rd("ref0", TKS_OFS_CNT_BASE + TKS_CNT_REF_OFS, P >> c, 2);
         rd("irq_stat", TKS_OFS_IRQ_STAT, 32'h4);
         check("irq_masked", 32'h0, {31'h0, irq});
         bus(1'b1, TKS_OFS_IRQ_STAT, 32'h4);
         rd("irq_stat", TKS_OFS_IRQ_STAT, 32'h0);
         bus(1'b1, TKS_OFS_CTRL, c);
         rd("cf0", TKS_OFS_CNT_BASE, 32'h0);
         rd("ref0", TKS_OFS_CNT_BASE + TKS_CNT_REF_OFS, 32'h0);
         rd("preset", TKS_OFS_PRESET, 32'hf0);
         rd("ctrl", TKS_OFS_CTRL, c);
         check("osc", 32'h0, 32'(osc));
      end
      $display("test scan done");
      bus(1'b1, TKS_OFS_IRQ_MASK, 32'h4);
      bus(1'b1, TKS_OFS_CTRL, 32'h24);
      t0 = cyc_n;
      // Clock enable low for 20 cycles must only stretch the slot
      ce <= 1'b0;
      repeat (20) @(posedge clk);
      ce <= 1'b1;
      wait_slot();
      check("frozen_time", P + 22, cyc_n - t0, 4);
      rd("cf0", TKS_OFS_CNT_BASE, P, 2);
      rd("cf1", TKS_OFS_CNT_BASE + TKS_CNT_STRIDE, P / 2, 2);
      check("irq", 32'h1, {31'h0, irq});
      bus(1'b1, TKS_OFS_IRQ_STAT, 32'h4);
      repeat (2) @(posedge clk);
      check("irq", 32'h0, {31'h0, irq});
      bus(1'b1, TKS_OFS_CTRL, 32'h0);
      $display("test irq done");
      // Reset in mid-run, with a scan going and a preset and mask set
      bus(1'b1, TKS_OFS_CTRL, 32'h27);
      srst <= 1'b1;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      rd("ctrl", TKS_OFS_CTRL, 32'h0);
      rd("preset", TKS_OFS_PRESET, 32'h0);
      rd("irq_mask", TKS_OFS_IRQ_MASK, 32'h0);
      check("osc", 32'h0, 32'(osc));
      $display("test second reset done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
